// file: host_port_master.sv
// host end: serial master, sclk divided down from i_clk
// assumes one command at a time on the user side
`timescale 1ns/10ps
`include "serial_port_defines.svh"
module host_port_master
  import serial_port_pkg::*;
#(
  parameter int SRAD_CYC     = `SP_US_CYC(`SP_SRAD_US),
  parameter int SRAD_MOT_CYC = `SP_US_CYC(`SP_SRAD_MOT_US),
  parameter int GAP_CYC      = `SP_US_CYC(`SP_SWW_US),
  parameter int HALF_CYC     = `SP_NS_CYC(`SP_SCLK_HIGH_NS)
)
(
  input  wire logic      i_clk,
  input  wire logic      i_rstn,
  input  wire logic      i_cmd_valid,
  input  wire logic      i_cmd_write,
  input  wire reg_addr_t i_cmd_addr,
  input  wire reg_data_t i_cmd_data,
  output logic           o_cmd_ready,
  output logic           o_rd_valid,
  output reg_data_t      o_rd_data,
  serial_port_if.master  port
);
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WAIT, S_DATA, S_GAP} st_e;
  st_e         st_r;
  logic [15:0] tmr_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic        wr_r;
  logic        hi_r;
  logic        sclk_r;
  logic        sel_r;
  logic [7:0]  rx_r;
  logic [1:0]  miso_s_r;
  reg_data_t   data_r;
  reg_addr_t   addr_r;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      miso_s_r <= 2'h0;
    else
      miso_s_r <= {miso_s_r[0], port.miso_o};
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r <= S_IDLE; sclk_r <= 1'b1; sel_r <= 1'b1; tmr_r <= 16'h0000;
      bit_r <= 4'h0; sh_r <= 8'h00; wr_r <= 1'b0; hi_r <= 1'b1;
      rx_r <= 8'h00; data_r <= 8'h00; o_rd_valid <= 1'b0; o_rd_data <= 8'h00;
      addr_r <= 7'h00;
    end
    else
    begin
      o_rd_valid <= 1'b0;
      if (tmr_r != 16'h0000)
        tmr_r <= tmr_r - 16'h0001;
      else
        case (st_r)
          S_IDLE:
            if (i_cmd_valid)
            begin
              sel_r  <= 1'b0;
              sh_r   <= {i_cmd_write, i_cmd_addr};
              data_r <= i_cmd_data;
              addr_r <= i_cmd_addr;
              wr_r   <= i_cmd_write;
              bit_r  <= 4'h0;
              hi_r   <= 1'b1;
              tmr_r  <= 16'(HALF_CYC);
              st_r   <= S_ADDR;
            end
          S_ADDR, S_DATA:
          begin
            // clock high phase at least the hold time
            tmr_r <= 16'(HALF_CYC);
            if (hi_r)
            begin
              sclk_r <= 1'b0;
              hi_r   <= 1'b0;
              // mosi shifts only on falls and loads only while sclk sits high, so it never races the sampling rise
              if (bit_r != 4'h0)
                sh_r <= {sh_r[6:0], 1'b0};
            end
            else
            begin
              sclk_r <= 1'b1;
              hi_r   <= 1'b1;
              rx_r   <= {rx_r[6:0], miso_s_r[1]};
              bit_r  <= bit_r + 4'h1;
              if (bit_r == `SP_BYTE_BITS - 4'h1)
              begin
                bit_r <= 4'h0;
                if (st_r == S_ADDR)
                begin
                  st_r <= S_WAIT;
                  tmr_r <= wr_r ? 16'(HALF_CYC) :
                           (addr_r == `SP_MOTION_ADDR || addr_r == `SP_MOTION_BURST) ?
                           16'(SRAD_MOT_CYC) : 16'(SRAD_CYC);
                end
                else
                begin
                  st_r <= S_GAP;
                  o_rd_valid <= ~wr_r;
                  o_rd_data  <= {rx_r[6:0], miso_s_r[1]};
                  tmr_r <= 16'(HALF_CYC);
                end
              end
            end
          end
          S_WAIT:
          begin
            // data byte goes out only after the clock has sat high through the gap
            st_r <= S_DATA;
            sh_r <= data_r;
          end
          default:
          begin
            sel_r <= 1'b1;
            tmr_r <= 16'(GAP_CYC);
            st_r  <= S_IDLE;
          end
        endcase
    end
  end

  assign port.sclk            = sclk_r;
  assign port.mosi            = sh_r[7];
  assign port.port_select_low = sel_r;
  assign o_cmd_ready          = (st_r == S_IDLE) && (tmr_r == 16'h0000);
endmodule // host_port_master

// file: sensor_port_slave.sv
// sensor end: serial slave clocked by the link clock sclk
// assumes a register file on i_clk that answers within the address-data gap
`timescale 1ns/10ps
`include "serial_port_defines.svh"
// What this block does
// - only the master ever starts a transfer
// - master makes clock; slave only receives it
// - port inactive in power-down or reset
// - select high: ignore inputs, data-out undriven
// - port enabled only after select falls
// - select high mid-transaction discards a write; a read is already requested once its address byte is in
// - master frames each transaction with select
// - burst ended only by raising select
// - write: address byte msb 1, data byte
// - slave samples mosi on rising sclk
// - read: address msb 0, device returns byte
// - read data changes on falling sclk
// - output held until next falling edge
// - master waits 50 us before read data
// - motion reads need 75 us gap
// - writes spaced 50 us apart
// - select high 4 us leaves burst
module sensor_port_slave
  import serial_port_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rstn,
  input  wire logic      i_reset,
  input  wire logic      i_power_down_low,
  input  wire reg_data_t i_rd_data,
  output logic           o_wr_valid,
  output reg_addr_t      o_wr_addr,
  output reg_data_t      o_wr_data,
  output logic           o_rd_req,
  output reg_addr_t      o_rd_addr,
  serial_port_if.slave   port
);
  // ------------------------------------------------------------
  // link side on sclk
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_ADDR, ST_WDATA, ST_RDATA, ST_DONE} phase_e;
  phase_e    phase_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  reg_addr_t  addr_r;
  logic       wr_tog_r;
  logic       rd_tog_r;
  reg_data_t  wdata_r;
  reg_data_t  tx_r;
  logic       oe_r;
  logic       blocked;
  logic [1:0] rst_sync_r;
  logic [1:0] pd_sync_r;

  // ------------------------------------------------------------
  // reset and power-down pins onto i_clk
  // ------------------------------------------------------------
  // port counts as blocked while the core itself is in reset
  // a pin pulse shorter than one i_clk cycle may be missed
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_sync_r <= 2'h3;
      pd_sync_r  <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], i_reset};
      pd_sync_r  <= {pd_sync_r[0], i_power_down_low};
    end
  end

  // async clear by select high or blocking state resets the frame state and data out; the toggles and wdata_r keep their values
  assign blocked = rst_sync_r[1] | ~pd_sync_r[1];
  wire  port_clr_n = port.port_select_low == 1'b0 && !blocked;

  always_ff @(posedge port.sclk or negedge port_clr_n)
  begin
    if (!port_clr_n)
    begin
      phase_r <= ST_ADDR;
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
      addr_r  <= 7'h00;
    end
    else
    begin
      case (phase_r)
        ST_ADDR:
        begin
          shift_r <= {shift_r[6:0], port.mosi};
          cnt_r   <= cnt_r + 4'h1;
          if (cnt_r == `SP_BYTE_BITS - 4'h1)
          begin
            addr_r  <= {shift_r[5:0], port.mosi};
            cnt_r   <= 4'h0;
            phase_r <= shift_r[6] ? ST_WDATA : ST_RDATA;
          end
        end
        ST_WDATA:
        begin
          shift_r <= {shift_r[6:0], port.mosi};
          cnt_r   <= cnt_r + 4'h1;
          if (cnt_r == `SP_BYTE_BITS - 4'h1)
            phase_r <= ST_DONE;
        end
        ST_RDATA:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `SP_BYTE_BITS - 4'h1)
            phase_r <= ST_DONE;
        end
        // burst and trailing clocks wait for select to rise
        default: phase_r <= ST_DONE;
      endcase
    end
  end

  // write commits only once the whole data byte has arrived
  always_ff @(posedge port.sclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_tog_r <= 1'b0;
      wdata_r  <= 8'h00;
    end
    else if (port_clr_n && phase_r == ST_WDATA && cnt_r == `SP_BYTE_BITS - 4'h1)
    begin
      wdata_r  <= {shift_r[6:0], port.mosi};
      wr_tog_r <= ~wr_tog_r;
    end
  end

  always_ff @(posedge port.sclk or negedge i_rstn)
  begin
    if (!i_rstn)
      rd_tog_r <= 1'b0;
    else if (port_clr_n && phase_r == ST_ADDR && cnt_r == 4'h7 && !shift_r[6])
      rd_tog_r <= ~rd_tog_r;
  end

  // data out changes on falling edges and holds until the next one
  always_ff @(negedge port.sclk or negedge port_clr_n)
  begin
    if (!port_clr_n)
    begin
      tx_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else if (phase_r == ST_RDATA)
    begin
      oe_r <= 1'b1;
      if (cnt_r == 4'h0)
        tx_r <= i_rd_data;
      else
        tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  assign port.miso_o  = tx_r[7];
  assign port.miso_oe = oe_r & port_clr_n;

  // ------------------------------------------------------------
  // crossing to i_clk: toggles, payload stable behind them
  // ------------------------------------------------------------
  logic [2:0] wsync_r;
  logic [2:0] rsync_r;
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wsync_r <= 3'h0;
      rsync_r <= 3'h0;
    end
    else
    begin
      wsync_r <= {wsync_r[1:0], wr_tog_r};
      rsync_r <= {rsync_r[1:0], rd_tog_r};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_wr_valid <= 1'b0;
      o_wr_addr  <= 7'h00;
      o_wr_data  <= 8'h00;
      o_rd_req   <= 1'b0;
      o_rd_addr  <= 7'h00;
    end
    else
    begin
      o_wr_valid <= wsync_r[2] ^ wsync_r[1];
      o_rd_req   <= rsync_r[2] ^ rsync_r[1];
      if (wsync_r[2] ^ wsync_r[1])
      begin
        o_wr_addr <= addr_r;
        o_wr_data <= wdata_r;
      end
      if (rsync_r[2] ^ rsync_r[1])
        o_rd_addr <= addr_r;
    end
  end
endmodule // sensor_port_slave

// file: sensor_serial_port_slave_tb.sv
// bench: host end talks to sensor end, register file modelled here
// assumes both ends share the 25 MHz core clock
`timescale 1ns/10ps
module sensor_serial_port_slave_tb;
  import serial_port_pkg::*;
  logic      i_clk, i_rstn, cmd_valid, cmd_write, cmd_ready;
  logic      rd_valid, wr_valid, rd_req, sns_reset, pwr_low;
  reg_addr_t cmd_addr, wr_addr, rd_addr;
  reg_data_t cmd_data, rd_data, wr_data, reg_rd;
  reg_data_t mem [128];
  reg_data_t ref_r [128];
  reg_addr_t corner_a [5] = '{7'h00, 7'h7F, 7'h02, 7'h55, 7'h50};
  reg_data_t corner_d [5] = '{8'hFF, 8'h00, 8'hA5, 8'h5A, 8'h3C};
  int        miscompares = 0, cmp_count = 0, cyc = 0, wr_seen = 0, rd_seen = 0;
  // ----------------------------------------
  // ends and checker
  // ----------------------------------------
  serial_port_if port_if ();
  host_port_master #(.SRAD_CYC(20), .SRAD_MOT_CYC(30), .GAP_CYC(20), .HALF_CYC(7))
  host_port_master_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data),
    .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .port(port_if.master));
  sensor_port_slave sensor_port_slave_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_reset(sns_reset), .i_power_down_low(pwr_low), .i_rd_data(reg_rd),
    .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_req(rd_req),
    .o_rd_addr(rd_addr), .port(port_if.slave));
  serial_port_properties serial_port_properties_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .sclk(port_if.sclk), .mosi(port_if.mosi), .miso_o(port_if.miso_o),
    .miso_oe(port_if.miso_oe), .port_select_low(port_if.port_select_low));
  // register file behind the sensor end
  assign reg_rd = mem[rd_addr];
  always @(posedge i_clk)
    if (wr_valid === 1'b1)
      mem[wr_addr] <= wr_data;
  always @(negedge i_clk)
    if (wr_valid === 1'b1)
      wr_seen++;
  always @(negedge i_clk)
    if (rd_req === 1'b1)
      rd_seen++;
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // hang guard, well above the whole run
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, 0);
      finish_test();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic reg_data_t exp_rd(input reg_addr_t a);
    return ref_r[a];
  endfunction
  task automatic issue(input logic wr, input reg_addr_t a, input reg_data_t d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000)
    begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge i_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic do_cmd(input logic wr, input reg_addr_t a, input reg_data_t d);
    int n;
    int r;
    n = 0;
    r = rd_seen;
    issue(wr, a, d);
    while ((wr ? wr_valid : rd_valid) !== 1'b1 && n < 2000)
    begin
      @(negedge i_clk);
      n++;
    end
    check(8'(n == 2000), 8'h00);
    if (wr)
    begin
      check({1'b0, wr_addr}, {1'b0, a});
      check(wr_data, d);
      ref_r[a] = d;
    end
    else
    begin
      check(rd_data, exp_rd(a));
      check({1'b0, rd_addr}, {1'b0, a});
      check(8'(rd_seen - r), 8'h01);
    end
  endtask
  // blocks the sensor end from 60 cycles into a write until after the write ends
  task automatic blocked_write(input int k);
    int s;
    s = wr_seen;
    issue(1'b1, 7'h33, 8'hC3);
    repeat (60) @(posedge i_clk);
    if (k == 0)
      sns_reset <= 1'b1;
    else
      pwr_low <= 1'b0;
    repeat (300) @(posedge i_clk);
    sns_reset <= 1'b0;
    pwr_low <= 1'b1;
    check(8'(wr_seen - s), 8'h00);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    i_rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 7'h00;
    cmd_data = 8'h00;
    sns_reset = 1'b0;
    pwr_low = 1'b1;
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = 8'h00;
      ref_r[i] = 8'h00;
    end
    void'($urandom(32'h57c13a79));
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    foreach (corner_a[i])
      do_cmd(1'b1, corner_a[i], corner_d[i]);
    foreach (corner_a[i])
      do_cmd(1'b0, corner_a[i], 8'h00);
    repeat (40)
      do_cmd(1'($urandom), reg_addr_t'($urandom % 16), reg_data_t'($urandom));
    blocked_write(0);
    blocked_write(1);
    do_cmd(1'b0, 7'h33, 8'h00);
    finish_test();
  end
endmodule // sensor_serial_port_slave_tb

// file: serial_port_defines.svh
// constants for the sensor serial port: frame layout and host timing
// assumes a 25 MHz system clock on the host end
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
`define SP_BYTE_BITS        4'h8
`define SP_DIR_BIT          7
`define SP_MOTION_ADDR      7'h02
`define SP_MOTION_BURST     7'h50
`define SP_CLK_PERIOD_NS    40
`define SP_SRAD_US          50
`define SP_SRAD_MOT_US      75
`define SP_SWW_US           50
`define SP_BEXIT_US         4
`define SP_SCLK_HIGH_NS     250
`define SP_US_CYC(us)       (((us) * 1000 + `SP_CLK_PERIOD_NS - 1) / `SP_CLK_PERIOD_NS)
`define SP_NS_CYC(ns)       (((ns) + `SP_CLK_PERIOD_NS - 1) / `SP_CLK_PERIOD_NS)
`endif

// file: serial_port_if.sv
// wires between the serial master and the sensor port slave
// the master reads the data-out line directly; only the checker looks at its enable
`timescale 1ns/10ps
interface serial_port_if;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic port_select_low;
  modport master (output sclk, output mosi, output port_select_low, input miso_o, input miso_oe);
  modport slave  (input sclk, input mosi, input port_select_low, output miso_o, output miso_oe);
endinterface

// file: serial_port_pkg.sv
// types shared by both ends of the sensor serial port
// assumes serial_port_defines.svh for numbers
package serial_port_pkg;
  typedef logic [6:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
endpackage

// file: serial_port_properties.sv
// checker for the link between host end and sensor end
// assumes link signals sampled on the host core clock
`timescale 1ns/10ps
module serial_port_properties (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic port_select_low
);
  // ----------------------------------------
  // frame bookkeeping
  // ----------------------------------------
  logic [4:0] rise_cnt_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // counts rises only while selected; a frame is 16
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      rise_cnt_r <= 5'h00;
    else if (port_select_low)
      rise_cnt_r <= 5'h00;
    else if ($rose(sclk))
      rise_cnt_r <= rise_cnt_r + 5'h01;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sel_tristate_a: assert property (port_select_low |-> !miso_oe)
    else $error("miso driven while deselected");
  miso_hold_a: assert property (
    $past(miso_oe) && miso_oe && !$fell(sclk) |-> $stable(miso_o))
    else $error("miso moved off a falling edge");
  clk_idle_a: assert property (port_select_low |-> sclk)
    else $error("clock not idle high");
  mosi_stable_a: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("mosi changed at rising clock");
  clk_high_a: assert property ($rose(sclk) |-> sclk [*7])
    else $error("clock high too short");
  oe_data_a: assert property (miso_oe |-> rise_cnt_r >= 5'h08)
    else $error("miso driven during address byte");
  frame_bits_a: assert property ($rose(sclk) |-> !port_select_low && rise_cnt_r < 5'h10)
    else $error("clock outside frame");
  frame_len_a: assert property (
    $past(i_rstn) && $rose(port_select_low) |-> rise_cnt_r == 5'h10)
    else $error("frame not two bytes");
  cover property ($fell(port_select_low));
  cover property ($rose(miso_oe));
  cover property ($rose(port_select_low));
endmodule // serial_port_properties
